// ===== dv/interrogation_scheduler_tb_top.sv
`timescale 1ns/1ps
module interrogation_scheduler_tb_top;
    import interrogation_scheduler_pkg::*;
    logic              clk_i = 1'b0;
    logic              arst_n_i = 1'b0;
    logic              mode_c_i = 1'b0;
    tx_ctrl_t          tx_o;
    logic [SLOT_W-1:0] slot_o;
    int                rise_w [3];
    int                fall_w [3];
    logic              sel_bad_w;
    int                fail_count = 0;
    int                checked = 0;
    int                cycles = 0;
    int                seed = 32'hf180;
    int                sp;
    int                exp_q [$];

    always #5 clk_i = ~clk_i;

    interrogation_scheduler dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .mode_c_i(mode_c_i), .tx_o(tx_o),
                                 .slot_o(slot_o));
    tx_front_model far (.clk_i(clk_i), .arst_n_i(arst_n_i), .tx_i(tx_o), .rise_o(rise_w), .fall_o(fall_w),
                        .sel_bad_o(sel_bad_w));

    // ----------------------------------------
    // compare and close
    // ----------------------------------------
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        checked++;
        if (exp !== got) begin
            fail_count++;
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic final_report();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // hang guard, four interrogations need well under this
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            final_report();
        end
    end

    // ----------------------------------------
    // one interrogation per reset, both modes
    // ----------------------------------------
    initial begin
        for (int n = 0; n < 4; n++) begin
            @(negedge clk_i);
            arst_n_i = 1'b0;
            mode_c_i = (n < 2) ? n[0] : 1'($random(seed));
            exp_q.push_back(mode_c_i ? 2100 : 800);
            repeat (2) @(negedge clk_i);
            arst_n_i = 1'b1;
            repeat (2) @(negedge clk_i);
            check("slot", 32'h0, 32'(slot_o));
            check("antenna", 32'(ANT_FRONT), 32'(tx_o.interrogate));
            check("suppress", 32'(ANT_CENTER), 32'(tx_o.suppress));
            check("mode", 32'(mode_c_i), 32'(tx_o.mode_c));
            for (int k = 0; k < 3000 && fall_w[0] < 0; k++) @(negedge clk_i);
            sp = exp_q.pop_front();
            check("first width", 80, fall_w[2] - rise_w[2]);
            check("control delay", 200, rise_w[1] - rise_w[2]);
            check("control width", 80, fall_w[1] - rise_w[1]);
            check("second spacing", sp, rise_w[0] - rise_w[2]);
            check("second width", 80, fall_w[0] - rise_w[0]);
            check("control order", 1, 32'(rise_w[1] > fall_w[2] && fall_w[1] < rise_w[0]));
            check("select hold", 0, 32'(sel_bad_w));
            repeat (3) @(negedge clk_i);
            check("next slot", 32'h1, 32'(slot_o));
            check("idle antenna", 32'(ANT_NONE), 32'(tx_o.interrogate));
            $display("test %0d done mode_c %0d", n, mode_c_i);
        end
        final_report();
    end
endmodule

// ===== dv/tx_front_model.sv
`timescale 1ns/1ps
// transmitter side: logs pulse edges in cycles since reset release
module tx_front_model
    import interrogation_scheduler_pkg::*;
(
    // clock and reset
    input  wire logic     clk_i,
    input  wire logic     arst_n_i,
    // from scheduler
    input  wire tx_ctrl_t tx_i,
    // measurements, index 2 first, 1 control, 0 second
    output int            rise_o [3],
    output int            fall_o [3],
    output logic          sel_bad_o
);
    int         cyc;
    logic       act;
    logic [2:0] prev;
    wire  [2:0] now_w = {tx_i.first_mode_pulse, tx_i.suppression_control_pulse, tx_i.second_mode_pulse};
    wire        bad_w = (tx_i.interrogate == ANT_NONE) || (tx_i.suppress != ANT_CENTER);

    // edge capture, selects must stand from first rise to second fall
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cyc = 0;
            act = 1'b0;
            prev = 3'h0;
            sel_bad_o = 1'b0;
            rise_o = '{-1, -1, -1};
            fall_o = '{-1, -1, -1};
        end else begin
            cyc = cyc + 1;
            // window closes on the edge that sees the second pulse gone, selects may drop there
            if (prev[0] && !now_w[0]) act = 1'b0;
            if ((act || (|now_w)) && bad_w) sel_bad_o = 1'b1;
            for (int i = 0; i < 3; i++) begin
                if (now_w[i] && !prev[i]) rise_o[i] = cyc;
                if (!now_w[i] && prev[i]) fall_o[i] = cyc;
            end
            if (now_w[2]) act = 1'b1;
            prev = now_w;
        end
    end
endmodule

// ===== hw/interrogation_scheduler.sv
`timescale 1ns/1ps
module interrogation_scheduler
    import interrogation_scheduler_pkg::*;
(
    // clock and reset
    input  wire logic     clk_i,
    input  wire logic     arst_n_i,
    // configuration
    input  wire logic     mode_c_i,
    // transmitter control
    output tx_ctrl_t      tx_o,
    output logic [SLOT_W-1:0] slot_o
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SETUP = 2'b01,
        ST_PULSE = 2'b11
    } state_t;

    state_t              state_reg,  state_next;
    logic [CNT_W-1:0]    slot_cnt_reg, slot_cnt_next;
    logic [CNT_W-1:0]    pcnt_reg,   pcnt_next;
    logic [SLOT_W-1:0]   slot_reg,   slot_next;
    tx_ctrl_t            tx_reg,     tx_next;
    logic                mode_s1_reg, mode_s2_reg;

    // slot to antenna table
    function automatic antenna_t slot_antenna(input logic [SLOT_W-1:0] s);
        logic [SLOT_W-1:0] k;
        k = (s >= SLOT_W'(SLOTS/2)) ? s - SLOT_W'(SLOTS/2) : s;
        case (k)
            SLOT_W'(1): slot_antenna = ANT_LEFT;
            SLOT_W'(3): slot_antenna = ANT_BACK;
            SLOT_W'(5): slot_antenna = ANT_RIGHT;
            SLOT_W'(7): slot_antenna = ANT_CENTER;
            default:    slot_antenna = ANT_FRONT;
        endcase
    endfunction

    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire logic [CNT_W-1:0] second_at  = tx_reg.mode_c ? CNT_W'(MODE_C_CYC) : CNT_W'(MODE_A_CYC);
    wire logic [CNT_W-1:0] second_end = second_at + CNT_W'(PULSE_CYC);
    wire logic             slot_end = (slot_cnt_reg == CNT_W'(SLOT_CYCLES - 1));
    wire antenna_t         ant_now  = slot_antenna(slot_reg);
    wire antenna_t         supp_now = (ant_now == ANT_CENTER) ? ANT_NONE : ANT_CENTER;

    // sequencing
    always_comb begin
        state_next    = state_reg;
        slot_cnt_next = slot_end ? '0 : slot_cnt_reg + CNT_W'(1);
        slot_next     = slot_reg;
        pcnt_next     = pcnt_reg;
        tx_next       = tx_reg;
        tx_next.first_mode_pulse          = 1'b0;
        tx_next.suppression_control_pulse = 1'b0;
        tx_next.second_mode_pulse         = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (slot_cnt_reg == '0) begin
                    tx_next.interrogate = ant_now;
                    tx_next.suppress    = supp_now;
                    tx_next.mode_c      = mode_s2_reg;
                    pcnt_next           = '0;
                    state_next          = ST_SETUP;
                end
            end
            ST_SETUP: begin
                pcnt_next = pcnt_reg + CNT_W'(1);
                if (pcnt_reg == CNT_W'(SETUP_CYC - 1)) begin
                    pcnt_next  = '0;
                    state_next = ST_PULSE;
                end
            end
            ST_PULSE: begin
                pcnt_next = pcnt_reg + CNT_W'(1);
                // pulse width
                // all windows compare the current count, so each pulse is exactly its cycle count long
                tx_next.first_mode_pulse = (pcnt_reg < CNT_W'(PULSE_CYC));
                tx_next.suppression_control_pulse = (tx_reg.suppress != ANT_NONE)
                    && (pcnt_reg >= CNT_W'(SUPP_CYC)) && (pcnt_reg < CNT_W'(SUPP_CYC + PULSE_CYC));
                tx_next.second_mode_pulse = (pcnt_reg >= second_at)
                    && (pcnt_reg < second_end);
                // selects drop on the same edge as the second pulse falls, so they stand through it
                if (pcnt_reg == second_end) begin
                    slot_next           = (slot_reg == SLOT_W'(SLOTS - 1)) ? '0 : slot_reg + SLOT_W'(1);
                    tx_next.interrogate = ANT_NONE;
                    tx_next.suppress    = ANT_NONE;
                    state_next          = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // registers
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg    <= ST_IDLE;
            slot_cnt_reg <= '0;
            pcnt_reg     <= '0;
            slot_reg     <= '0;
            tx_reg       <= '0;
        end else begin
            state_reg    <= state_next;
            slot_cnt_reg <= slot_cnt_next;
            pcnt_reg     <= pcnt_next;
            slot_reg     <= slot_next;
            tx_reg       <= tx_next;
        end
    end

    // mode synchroniser, left out of reset so the first slot after reset sees the pin level
    always_ff @(posedge clk_i) begin
        mode_s1_reg <= mode_c_i;
        mode_s2_reg <= mode_s1_reg;
    end

    assign tx_o   = tx_reg;
    assign slot_o = slot_reg;

    // ----------------------------------------
    // check helpers
    // ----------------------------------------
    // pulse run lengths and cycles since the first mode pulse rose
    logic             first_prev_reg;
    logic [CNT_W-1:0] first_age_reg;
    logic [CNT_W-1:0] first_len_reg;
    logic [CNT_W-1:0] ctrl_len_reg;
    logic [CNT_W-1:0] second_len_reg;
    wire logic        first_rise = tx_reg.first_mode_pulse && !first_prev_reg;

    // run length of a level, zero while it is low
    function automatic logic [CNT_W-1:0] run_len(input logic level, input logic [CNT_W-1:0] n);
        run_len = level ? n + CNT_W'(1) : '0;
    endfunction

    // counters stand in for long repetitions and the second pulse delays in the properties
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            first_prev_reg <= 1'b0;
            first_age_reg  <= '0;
            first_len_reg  <= '0;
            ctrl_len_reg   <= '0;
            second_len_reg <= '0;
        end else begin
            first_prev_reg <= tx_reg.first_mode_pulse;
            first_age_reg  <= first_rise ? CNT_W'(1) : first_age_reg + CNT_W'(1);
            first_len_reg  <= run_len(tx_reg.first_mode_pulse, first_len_reg);
            ctrl_len_reg   <= run_len(tx_reg.suppression_control_pulse, ctrl_len_reg);
            second_len_reg <= run_len(tx_reg.second_mode_pulse, second_len_reg);
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_first_width: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        $fell(tx_reg.first_mode_pulse) |-> first_len_reg == CNT_W'(PULSE_CYC))
        else $error("first pulse width wrong");
    a_first_bound: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        tx_reg.first_mode_pulse |-> first_len_reg < CNT_W'(PULSE_CYC))
        else $error("first pulse too long");
    a_ctrl_width: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        $fell(tx_reg.suppression_control_pulse) |-> ctrl_len_reg == CNT_W'(PULSE_CYC))
        else $error("control pulse width wrong");
    a_second_width: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        $fell(tx_reg.second_mode_pulse) |-> second_len_reg == CNT_W'(PULSE_CYC))
        else $error("second pulse width wrong");
    a_supp_delay: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        $rose(tx_reg.first_mode_pulse) && tx_reg.suppress == ANT_CENTER
        |-> ##200 $rose(tx_reg.suppression_control_pulse))
        else $error("control pulse delay wrong");
    a_mode_a_gap: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        $rose(tx_reg.second_mode_pulse) && !tx_reg.mode_c |-> first_age_reg == CNT_W'(MODE_A_CYC))
        else $error("mode A spacing wrong");
    a_mode_a_due: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        tx_reg.interrogate != ANT_NONE && !tx_reg.mode_c && first_age_reg == CNT_W'(MODE_A_CYC)
        |-> $rose(tx_reg.second_mode_pulse))
        else $error("mode A second pulse missing");
    a_mode_c_gap: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        $rose(tx_reg.second_mode_pulse) && tx_reg.mode_c |-> first_age_reg == CNT_W'(MODE_C_CYC))
        else $error("mode C spacing wrong");
    a_mode_c_due: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        tx_reg.interrogate != ANT_NONE && tx_reg.mode_c && first_age_reg == CNT_W'(MODE_C_CYC)
        |-> $rose(tx_reg.second_mode_pulse))
        else $error("mode C second pulse missing");
    a_center_nosup: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        tx_reg.interrogate == ANT_CENTER |-> !tx_reg.suppression_control_pulse && tx_reg.suppress == ANT_NONE)
        else $error("suppression sent on center");
    a_dir_sup: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        $rose(tx_reg.first_mode_pulse) && tx_reg.interrogate != ANT_CENTER |-> tx_reg.suppress == ANT_CENTER)
        else $error("no suppression antenna");
    a_sel_valid: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        tx_reg.first_mode_pulse || tx_reg.second_mode_pulse |-> tx_reg.interrogate != ANT_NONE
        && $stable(tx_reg.interrogate))
        else $error("antenna select not held");
    a_ctrl_inside: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        tx_reg.suppression_control_pulse |-> !tx_reg.first_mode_pulse && !tx_reg.second_mode_pulse)
        else $error("control pulse overlaps");
    a_slot_order: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        tx_reg.first_mode_pulse |-> tx_reg.interrogate == slot_antenna(slot_reg))
        else $error("slot antenna wrong");

endmodule

// ===== hw/interrogation_scheduler_pkg.sv
package interrogation_scheduler_pkg;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_PS = 10000;
    localparam int SLOT_RATE_HZ  = 18;
    localparam int CLK_RATE_HZ   = 100000000;
    localparam int SLOT_CYCLES   = CLK_RATE_HZ / SLOT_RATE_HZ;
    localparam int PULSE_NS      = 800;
    localparam int SUPP_DELAY_NS = 2000;
    localparam int MODE_A_NS     = 8000;
    localparam int MODE_C_NS     = 21000;
    localparam int PULSE_CYC     = PULSE_NS * 1000 / CLK_PERIOD_PS;
    localparam int SUPP_CYC      = SUPP_DELAY_NS * 1000 / CLK_PERIOD_PS;
    localparam int MODE_A_CYC    = MODE_A_NS * 1000 / CLK_PERIOD_PS;
    localparam int MODE_C_CYC    = MODE_C_NS * 1000 / CLK_PERIOD_PS;
    localparam int SETUP_CYC     = 2;
    localparam int CNT_W         = 24;
    localparam int SLOTS         = 18;
    localparam int SLOT_W        = 5;

    // ----------------------------------------
    // antenna codes
    // ----------------------------------------
    typedef enum logic [2:0] {
        ANT_NONE   = 3'h0,
        ANT_FRONT  = 3'h1,
        ANT_LEFT   = 3'h2,
        ANT_BACK   = 3'h3,
        ANT_RIGHT  = 3'h4,
        ANT_CENTER = 3'h5
    } antenna_t;

    typedef struct packed {
        antenna_t interrogate;
        antenna_t suppress;
        logic     first_mode_pulse;
        logic     suppression_control_pulse;
        logic     second_mode_pulse;
        logic     mode_c;
    } tx_ctrl_t;

endpackage
